// ===== pllc_cfg.svh
// Function
// - Bypass bit low uses reference divider; high passes reference at ratio one.
// - Divider field bits 15..13 selects ratio 2 (010) to 7 (111).
// - Two independent banks; bank two is default, mode pin high selects it.
// - Loop locks oscillator to effective divider times reference over ratio.
// - Numerator split: upper sixteen bits and lower eight bits in two registers.
// - Feedback uses dual-modulus prescaler with fractional sequence, step fpd/2^24.
// - Code 31, low-current clear gives 120uA; low-current set gives 30uA.
// - Pump current equals full-scale times code divided by 31.
// - Auto bandwidth correction takes current from measured gain; off after reset.
// - Active filter bit high enables op-amp; low disables it, pin hi-z.
// - Standby high keeps oscillator running with enable low; else it stops.
// - Trim holds four-bit coarse load, reset 0100, and fine bit, reset 0.
// - Four-bit field programs mixer bias between 15mA and 35mA.
// - Band selection starts on each enable rise, using active bank values.
// - Dual-bank bit set: mode pin low selects bank one, high bank two.
`ifndef PLLC_CFG_SVH
`define PLLC_CFG_SVH
`define PLLC_AW          4
`define PLLC_DW          16
`define PLLC_OFS_CONFIG_ONE    4'h0
`define PLLC_OFS_CLKDIV  4'h1
`define PLLC_OFS_CONFIG_TWO    4'h2
`define PLLC_OFS_CONFIG_FOUR    4'h3
`define PLLC_OFS_BANK1   4'h4
`define PLLC_OFS_BANK2   4'h8
`define PLLC_OFS_STATUS  4'hF
`define PLLC_BK_INT      2'h0
`define PLLC_BK_UP       2'h1
`define PLLC_BK_LO       2'h2
`define PLLC_C1_ACT      0
`define PLLC_C1_POL      1
`define PLLC_C1_DUAL     2
`define PLLC_C1_STBY     3
`define PLLC_C1_LOWI     4
`define PLLC_C1_AUTO     5
`define PLLC_CONFIG_ONE_RST    6'h03
`define PLLC_DIV_LSB     13
`define PLLC_BYP_BIT     12
`define PLLC_RATIO_RST   3'h2
`define PLLC_BYP_RST     1'h1
`define PLLC_MIX_RST     4'h4
`define PLLC_COARSE_RST  4'h4
`define PLLC_FINE_RST    1'h0
`define PLLC_N_RST       10'h05C
`define PLLC_FLL_RST     2'h1
`define PLLC_CP_RST      5'h1F
`define PLLC_CP_MAX      5'h1F
`define PLLC_ICP_FULL    7'h78
`define PLLC_ICP_LOW     7'h1E
`define PLLC_FRAC_W      24
`define PLLC_BAND_TICKS  1500
`endif

// ===== pllc_pkg.sv
package pllc_pkg;
	typedef enum logic
	{
		PLLC_BANK_ONE = 1'b0,
		PLLC_BANK_TWO = 1'b1
	} pllc_bank_t;
	typedef enum logic
	{
		PLLC_BAND_IDLE = 1'b0,
		PLLC_BAND_RUN  = 1'b1
	} pllc_band_t;
endpackage : pllc_pkg

// ===== pllc_frac_seq.sv
`timescale 1ns/1ps
`default_nettype none
module pllc_frac_seq #(
	parameter int FW = 24
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic          adv_i,
	input  wire logic [FW-1:0] frac_i,
	output logic               carry_o,
	output logic      [FW-1:0] acc_o
);
	logic [FW:0]   sum;
	logic [FW-1:0] acc_reg;

	assign sum     = {1'b0, acc_reg} + {1'b0, frac_i};
	assign carry_o = sum[FW];
	assign acc_o   = acc_reg;

	// Overflow of the accumulator selects the N+1 modulus
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			acc_reg <= '0;
		else if (adv_i)
			acc_reg <= sum[FW-1:0];
	end
endmodule : pllc_frac_seq
`default_nettype wire

// ===== pllc_top.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pllc_cfg.svh"
module pllc_top #(
	parameter int BAND_TICKS = `PLLC_BAND_TICKS
) (
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	input  wire logic [`PLLC_AW-1:0] reg_addr_i,
	input  wire logic [`PLLC_DW-1:0] reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [`PLLC_DW-1:0] reg_rdata_o,
	input  wire logic                chip_enable_pin_i,
	input  wire logic                mode_pin_i,
	input  wire logic [4:0]          vco_gain_code_i,
	output logic                     pd_tick_o,
	output logic      [9:0]          fb_div_o,
	output logic      [1:0]          freq_lock_factor_o,
	output logic      [6:0]          pump_current_o,
	output logic                     opamp_en_o,
	output logic                     filter_hiz_o,
	output logic                     detector_polarity_o,
	output logic                     xo_run_o,
	output logic                     analog_en_o,
	output logic                     band_start_o,
	output logic                     band_busy_o,
	output logic                     active_bank_o,
	output logic      [3:0]          xtal_load_coarse_o,
	output logic                     xtal_load_fine_o,
	output logic      [3:0]          mixer_bias_current_o
);
	localparam int FW = `PLLC_FRAC_W;
	localparam logic [10:0] BAND_LAST = 11'(BAND_TICKS - 1);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	logic [1:0] en_sync_reg;
	logic [1:0] mode_sync_reg;
	logic       en_prev_reg;
	logic       en_s;
	logic       mode_s;
	logic       en_rise;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			en_sync_reg   <= 2'h0;
			mode_sync_reg <= 2'h0;
			en_prev_reg   <= 1'h0;
		end
		else
		begin
			en_sync_reg   <= {en_sync_reg[0], chip_enable_pin_i};
			mode_sync_reg <= {mode_sync_reg[0], mode_pin_i};
			en_prev_reg   <= en_sync_reg[1];
		end
	end
	assign en_s    = en_sync_reg[1];
	assign mode_s  = mode_sync_reg[1];
	assign en_rise = en_s && !en_prev_reg;

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	logic [5:0] config_one_reg;
	logic [2:0] ratio_reg;
	logic       ref_div_bypass_reg;
	logic [3:0] mixer_bias_reg;
	logic [3:0] xtal_coarse_reg;
	logic       xtal_fine_reg;
	logic       wr_config_one;
	logic       wr_clkdiv;
	logic       wr_config_two;
	logic       wr_config_four;
	assign wr_config_one   = reg_wr_i && (reg_addr_i == `PLLC_OFS_CONFIG_ONE);
	assign wr_clkdiv = reg_wr_i && (reg_addr_i == `PLLC_OFS_CLKDIV);
	assign wr_config_two   = reg_wr_i && (reg_addr_i == `PLLC_OFS_CONFIG_TWO);
	assign wr_config_four   = reg_wr_i && (reg_addr_i == `PLLC_OFS_CONFIG_FOUR);
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			config_one_reg     <= `PLLC_CONFIG_ONE_RST;
			ratio_reg          <= `PLLC_RATIO_RST;
			ref_div_bypass_reg <= `PLLC_BYP_RST;
			mixer_bias_reg     <= `PLLC_MIX_RST;
			xtal_coarse_reg    <= `PLLC_COARSE_RST;
			xtal_fine_reg      <= `PLLC_FINE_RST;
		end
		else
		begin
			if (wr_config_one)
				config_one_reg <= reg_wdata_i[5:0];
			if (wr_clkdiv)
			begin
				ratio_reg          <= reg_wdata_i[`PLLC_DIV_LSB +: 3];
				ref_div_bypass_reg <= reg_wdata_i[`PLLC_BYP_BIT];
			end
			if (wr_config_two)
				mixer_bias_reg <= reg_wdata_i[3:0];
			if (wr_config_four)
			begin
				xtal_coarse_reg <= reg_wdata_i[3:0];
				xtal_fine_reg   <= reg_wdata_i[4];
			end
		end
	end
	// --------------------------------------------------------------
	// Programming banks
	// --------------------------------------------------------------
	logic [9:0] bk_int_reg [2];
	logic [1:0] bk_fll_reg [2];
	logic [15:0] bk_up_reg [2];
	logic [7:0] bk_lo_reg  [2];
	logic [4:0] bk_cp_reg  [2];
	genvar b;
	for (b = 0; b < 2; b++)
	begin : g_bank
		localparam logic [`PLLC_AW-1:0] BASE = `PLLC_AW'(`PLLC_OFS_BANK1 + 4 * b);
		wire hit    = reg_wr_i && (reg_addr_i[`PLLC_AW-1:2] == BASE[`PLLC_AW-1:2]);
		wire wr_int = hit && (reg_addr_i[1:0] == `PLLC_BK_INT);
		wire wr_up  = hit && (reg_addr_i[1:0] == `PLLC_BK_UP);
		wire wr_lo  = hit && (reg_addr_i[1:0] == `PLLC_BK_LO);
		always_ff @(posedge clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
			begin
				bk_int_reg[b] <= `PLLC_N_RST;
				bk_fll_reg[b] <= `PLLC_FLL_RST;
				bk_up_reg[b]  <= 16'h0000;
				bk_lo_reg[b]  <= 8'h00;
				bk_cp_reg[b]  <= `PLLC_CP_RST;
			end
			else
			begin
				if (wr_int)
				begin
					bk_int_reg[b] <= reg_wdata_i[9:0];
					bk_fll_reg[b] <= reg_wdata_i[11:10];
				end
				if (wr_up)
					bk_up_reg[b] <= reg_wdata_i;
				if (wr_lo)
				begin
					bk_lo_reg[b] <= reg_wdata_i[7:0];
					bk_cp_reg[b] <= reg_wdata_i[12:8];
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Active bank selection
	// --------------------------------------------------------------
	pllc_pkg::pllc_bank_t bank_sel;
	logic                 act;
	logic [9:0]           act_int;
	logic [FW-1:0]        act_frac;
	logic [4:0]           act_cp;
	assign bank_sel = config_one_reg[`PLLC_C1_DUAL] ?
		pllc_pkg::pllc_bank_t'(mode_s) : pllc_pkg::PLLC_BANK_TWO;
	assign act      = (bank_sel == pllc_pkg::PLLC_BANK_TWO);
	assign act_int  = bk_int_reg[act];
	assign act_frac = {bk_up_reg[act], bk_lo_reg[act]};
	assign act_cp   = bk_cp_reg[act];
	// --------------------------------------------------------------
	// Reference divider
	// --------------------------------------------------------------
	logic [3:0] ref_cfg;
	logic [3:0] ref_cfg_q_reg;
	logic [2:0] ref_cnt_reg;
	logic [2:0] ref_ratio;
	logic       ref_restart;
	logic       pd_tick;
	assign ref_cfg     = {ref_div_bypass_reg, ratio_reg};
	assign ref_restart = (ref_cfg != ref_cfg_q_reg);
	assign ref_ratio   = (ref_div_bypass_reg || ratio_reg < 3'h2) ? 3'h1 : ratio_reg;
	assign pd_tick     = (ref_cnt_reg == ref_ratio - 3'h1) && !ref_restart;
	assign pd_tick_o   = pd_tick;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ref_cfg_q_reg <= {`PLLC_BYP_RST, `PLLC_RATIO_RST};
			ref_cnt_reg   <= 3'h0;
		end
		else
		begin
			ref_cfg_q_reg <= ref_cfg;
			ref_cnt_reg   <= (ref_restart || pd_tick) ? 3'h0 : ref_cnt_reg + 3'h1;
		end
	end

	// --------------------------------------------------------------
	// Fractional feedback sequence
	// --------------------------------------------------------------
	logic          frac_carry;
	logic [9:0]    fb_div_reg;
	pllc_frac_seq #(
		.FW (FW)
	) u_frac (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.adv_i   (pd_tick),
		.frac_i  (act_frac),
		.carry_o (frac_carry),
		.acc_o   ()
	);
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			fb_div_reg <= `PLLC_N_RST;
		else if (pd_tick)
			fb_div_reg <= act_int + {9'h000, frac_carry};
	end
	assign fb_div_o = fb_div_reg;
	// --------------------------------------------------------------
	// Charge pump current
	// --------------------------------------------------------------
	logic [6:0]  pump_full;
	logic [4:0]  pump_code;
	logic [11:0] pump_prod;
	logic [11:0] pump_quot;
	assign pump_full = config_one_reg[`PLLC_C1_LOWI] ? `PLLC_ICP_LOW : `PLLC_ICP_FULL;
	assign pump_code = config_one_reg[`PLLC_C1_AUTO] ? vco_gain_code_i : act_cp;
	assign pump_prod = {5'h00, pump_full} * {7'h00, pump_code};
	assign pump_quot = pump_prod / {7'h00, `PLLC_CP_MAX};
	// --------------------------------------------------------------
	// Band selection sequencer
	// --------------------------------------------------------------
	pllc_pkg::pllc_band_t band_state_reg;
	pllc_pkg::pllc_band_t band_state_next;
	logic [10:0]          band_cnt_reg;
	logic [10:0]          band_cnt_next;
	always_comb
	begin
		band_state_next = band_state_reg;
		band_cnt_next   = band_cnt_reg;
		unique case (band_state_reg)
			pllc_pkg::PLLC_BAND_IDLE:
			begin
				if (en_rise)
				begin
					band_state_next = pllc_pkg::PLLC_BAND_RUN;
					band_cnt_next   = BAND_LAST;
				end
			end
			pllc_pkg::PLLC_BAND_RUN:
			begin
				if (en_rise)
					band_cnt_next = BAND_LAST;
				else if (!en_s)
					band_state_next = pllc_pkg::PLLC_BAND_IDLE;
				else if (pd_tick && band_cnt_reg == 11'h000)
					band_state_next = pllc_pkg::PLLC_BAND_IDLE;
				else if (pd_tick)
					band_cnt_next = band_cnt_reg - 11'h001;
			end
		endcase
	end
	// --------------------------------------------------------------
	// Registered outputs and direct output assignments
	// --------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			band_state_reg <= pllc_pkg::PLLC_BAND_IDLE;
			band_cnt_reg   <= 11'h000;
			band_start_o   <= 1'h0;
			pump_current_o <= 7'h00;
			opamp_en_o     <= 1'h0;
			filter_hiz_o   <= 1'h1;
			xo_run_o       <= 1'h0;
			analog_en_o    <= 1'h0;
		end
		else
		begin
			band_state_reg <= band_state_next;
			band_cnt_reg   <= band_cnt_next;
			band_start_o   <= en_rise;
			pump_current_o <= pump_quot[6:0];
			opamp_en_o     <= config_one_reg[`PLLC_C1_ACT];
			filter_hiz_o   <= !config_one_reg[`PLLC_C1_ACT];
			xo_run_o       <= en_s || config_one_reg[`PLLC_C1_STBY];
			analog_en_o    <= en_s;
		end
	end
	assign band_busy_o          = (band_state_reg == pllc_pkg::PLLC_BAND_RUN);
	assign active_bank_o        = act;
	assign freq_lock_factor_o   = bk_fll_reg[act];
	assign detector_polarity_o  = config_one_reg[`PLLC_C1_POL];
	assign xtal_load_coarse_o   = xtal_coarse_reg;
	assign xtal_load_fine_o     = xtal_fine_reg;
	assign mixer_bias_current_o = mixer_bias_reg;
	// --------------------------------------------------------------
	// Register read port
	// --------------------------------------------------------------
	logic [15:0] rd_bank;
	logic [15:0] rd_mux;
	logic        rd_bk;
	assign rd_bk   = reg_addr_i[3];
	assign rd_bank = (reg_addr_i[1:0] == `PLLC_BK_INT) ? {4'h0, bk_fll_reg[rd_bk], bk_int_reg[rd_bk]} :
		(reg_addr_i[1:0] == `PLLC_BK_UP) ? bk_up_reg[rd_bk] :
		(reg_addr_i[1:0] == `PLLC_BK_LO) ? {3'h0, bk_cp_reg[rd_bk], bk_lo_reg[rd_bk]} : 16'h0000;
	assign rd_mux  = (reg_addr_i == `PLLC_OFS_CONFIG_ONE) ? {10'h000, config_one_reg} :
		(reg_addr_i == `PLLC_OFS_CLKDIV) ? {ratio_reg, ref_div_bypass_reg, 12'h000} :
		(reg_addr_i == `PLLC_OFS_CONFIG_TWO) ? {12'h000, mixer_bias_reg} :
		(reg_addr_i == `PLLC_OFS_CONFIG_FOUR) ? {11'h000, xtal_fine_reg, xtal_coarse_reg} :
		(reg_addr_i[3:2] == 2'h1 || reg_addr_i[3:2] == 2'h2) ? rd_bank :
		(reg_addr_i == `PLLC_OFS_STATUS) ? {fb_div_reg, 3'h0, xo_run_o, band_busy_o, act} :
		16'h0000;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= 16'h0000;
		else
			reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_band_pulse;
		band_start_o ##1 !band_start_o;
	endsequence
	sequence s_band_busy;
		band_busy_o [*2];
	endsequence
	AST_BYPASS_EVERY: assert property ((ref_ratio == 3'h1 && !ref_restart) |-> pd_tick)
		else $error("bypass must tick every cycle");
	AST_DIV_RATIO: assert property (pd_tick |-> ref_cnt_reg == ref_ratio - 3'h1 && ref_ratio ==
		((ref_div_bypass_reg || ratio_reg < 3'h2) ? 3'h1 : ratio_reg))
		else $error("tick not at ratio");
	AST_RESTART: assert property (ref_restart |=> ref_cnt_reg == 3'h0 && !$past(pd_tick))
		else $error("divider did not restart");
	AST_BANK_DEFAULT: assert property (!config_one_reg[`PLLC_C1_DUAL] |-> active_bank_o)
		else $error("bank two not default");
	AST_BANK_MODE: assert property ((config_one_reg[`PLLC_C1_DUAL] && $stable(mode_sync_reg))
		|-> active_bank_o == mode_sync_reg[1])
		else $error("mode pin bank mismatch");
	AST_FB_CARRY: assert property (pd_tick |=> fb_div_o == $past(act_int) + {9'h000, $past(frac_carry)})
		else $error("feedback value wrong");
	AST_FB_HOLD: assert property (!pd_tick |=> $stable(fb_div_o))
		else $error("sequence advanced without tick");
	AST_PUMP_FULL: assert property ((nrst_i && act_cp == 5'h1F && !config_one_reg[`PLLC_C1_LOWI]
		&& !config_one_reg[`PLLC_C1_AUTO]) |=> pump_current_o == 7'h78)
		else $error("full-scale pump current wrong");
	AST_PUMP_LOW: assert property ((nrst_i && pump_code == 5'h1F && config_one_reg[`PLLC_C1_LOWI])
		|=> pump_current_o == 7'h1E)
		else $error("low pump current wrong");
	AST_PUMP_AUTO: assert property ((nrst_i && config_one_reg[`PLLC_C1_AUTO]
		&& !config_one_reg[`PLLC_C1_LOWI] && vco_gain_code_i == 5'h0A) |=> pump_current_o == 7'h26)
		else $error("auto correction ignores gain");
	AST_OPAMP: assert property (nrst_i |=> (opamp_en_o == $past(config_one_reg[`PLLC_C1_ACT])
		&& filter_hiz_o == !opamp_en_o))
		else $error("op-amp enable wrong");
	AST_XO: assert property ((!en_s && !config_one_reg[`PLLC_C1_STBY]) |=> !xo_run_o)
		else $error("oscillator kept running");
	AST_BAND_START: assert property ($rose(en_s) |=> s_band_pulse ##0 s_band_busy)
		else $error("band selection not started");
endmodule : pllc_top
`default_nettype wire

// ===== pllc_vco_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Analog loop stand-in: gain measurement
// ----------------------------------------
module pllc_vco_model #(
	parameter logic [4:0] GAIN = 5'h0A
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       pd_tick_i,
	input  wire logic       opamp_en_i,
	input  wire logic       detector_polarity_i,
	output logic      [4:0] gain_code_o,
	output logic            pol_bad_o
);
	// No measurement until the detector clock has ticked
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			gain_code_o <= 5'h00;
		else if (pd_tick_i)
			gain_code_o <= GAIN;
	end
	// Inverting op-amp needs the opposite detector sense
	assign pol_bad_o = opamp_en_i ^ detector_polarity_i;
endmodule : pllc_vco_model
`default_nettype wire

// ===== test_pllc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_pllc_top;
	logic        clk, nrst, wr, rd, en, mode;
	logic [3:0]  addr;
	logic [15:0] wd, rdv;
	logic [15:0] rdata;
	logic [9:0]  fb;
	logic [1:0]  fac;
	logic [6:0]  pump;
	logic [4:0]  gain;
	logic [3:0]  crs, mix;
	logic        tick, opa, hiz, pol, xo, ana, bst, busy, bank, fine, polbad;
	int          err_total, tests_run, tk, fs, bsn, cyc;
	logic        busy_seen;
	logic [15:0] ra [7];
	logic [15:0] rv [7];
	int          t0, s0;

	pllc_top #(.BAND_TICKS(4)) pllc_top_inst (.clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .chip_enable_pin_i(en),
		.mode_pin_i(mode), .vco_gain_code_i(gain), .pd_tick_o(tick), .fb_div_o(fb),
		.freq_lock_factor_o(fac), .pump_current_o(pump), .opamp_en_o(opa), .filter_hiz_o(hiz),
		.detector_polarity_o(pol), .xo_run_o(xo), .analog_en_o(ana), .band_start_o(bst),
		.band_busy_o(busy), .active_bank_o(bank), .xtal_load_coarse_o(crs), .xtal_load_fine_o(fine),
		.mixer_bias_current_o(mix));

	pllc_vco_model pllc_vco_model_inst (.clk_i(clk), .nrst_i(nrst), .pd_tick_i(tick),
		.opamp_en_i(opa), .detector_polarity_i(pol), .gain_code_o(gain), .pol_bad_o(polbad));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// Monitors and hang guard
	// ----------------------------------------
	always @(posedge clk)
	begin
		tk = tk + int'(tick);
		fs = fs + int'(fb);
		bsn = bsn + int'(bst);
		if (busy === 1'b1)
			busy_seen = 1'b1;
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %0t %s seen %0h want %0h", $time, m, s, e);
		end
	endtask : chk

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rdv = rdata;
	endtask : rreg

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		ra = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'h7};
		rv = '{16'h0003, 16'h5000, 16'h0004, 16'h0004, 16'h045C, 16'h1F00, 16'h0000};
		for (int i = 0; i < 7; i++)
		begin
			rreg(ra[i]);
			chk(rdv, rv[i], "reset value");
		end
		w(1);
		chk(rdata, 16'h0000, "read data stands one cycle");
		chk(pump, 7'h78, "pump full scale");
		chk({crs, fine, mix}, 9'h084, "trim and mixer outputs");
		chk({bank, fac, opa, hiz, pol}, 6'h2D, "bank and filter outputs");
		$display("test reset done");
	endtask : t_reset

	task automatic t_pump();
		wreg(4'h0, 16'h0013);
		w(3);
		chk(pump, 7'h1E, "low current full code");
		wreg(4'hA, 16'h0F00);
		w(3);
		chk(pump, 7'h0E, "low current code 15");
		wreg(4'h0, 16'h0003);
		w(3);
		chk(pump, 7'h3A, "pump code 15");
		wreg(4'h0, 16'h0023);
		w(3);
		chk(pump, 7'h26, "auto gain pump");
		wreg(4'h0, 16'h0003);
		wreg(4'hA, 16'h1F00);
		w(3);
		chk(pump, 7'h78, "pump restored");
		$display("test pump done");
	endtask : t_pump

	task automatic t_filter();
		wreg(4'h0, 16'h0000);
		w(2);
		chk({opa, hiz, pol, polbad}, 4'h4, "passive filter");
		wreg(4'h0, 16'h0003);
		w(2);
		chk({opa, hiz, pol, polbad}, 4'hA, "active filter");
		$display("test filter done");
	endtask : t_filter

	task automatic t_xo();
		chk(xo, 1'b0, "oscillator stopped");
		wreg(4'h0, 16'h000B);
		w(3);
		chk({xo, ana}, 2'h2, "standby keeps oscillator");
		wreg(4'h0, 16'h0003);
		w(3);
		chk(xo, 1'b0, "standby off");
		$display("test oscillator done");
	endtask : t_xo

	task automatic t_band();
		bsn = 0;
		busy_seen = 1'b0;
		@(posedge clk);
		en <= 1'b1;
		w(14);
		chk(bsn, 1, "one band start");
		chk({busy_seen, busy, xo, ana}, 4'hB, "band run ended");
		@(posedge clk);
		en <= 1'b0;
		w(5);
		chk({xo, ana}, 2'h0, "enable low");
		$display("test band done");
	endtask : t_band

	task automatic t_frac();
		wreg(4'h9, 16'h8000);
		w(8);
		s0 = fs;
		w(64);
		chk(fs - s0, 5920, "half fraction average");
		wreg(4'h9, 16'hCF32);
		wreg(4'hA, 16'h1F84);
		rreg(4'h9);
		chk(rdv, 16'hCF32, "upper numerator");
		rreg(4'hA);
		chk(rdv, 16'h1F84, "lower numerator");
		rreg(4'h8);
		chk(rdv, 16'h045C, "integer field");
		wreg(4'h9, 16'h0000);
		wreg(4'hA, 16'h1F00);
		$display("test fraction done");
	endtask : t_frac

	task automatic t_div();
		wreg(4'h1, 16'h6000);
		w(3);
		t0 = tk;
		w(30);
		chk(tk - t0, 10, "ratio three");
		wreg(4'h1, 16'hE000);
		w(3);
		t0 = tk;
		w(35);
		chk(tk - t0, 5, "ratio seven");
		wreg(4'h1, 16'hF000);
		w(3);
		t0 = tk;
		w(10);
		chk(tk - t0, 10, "bypass");
		$display("test divider done");
	endtask : t_div

	task automatic t_bank();
		wreg(4'h4, 16'h0014);
		wreg(4'h0, 16'h0007);
		@(posedge clk);
		mode <= 1'b0;
		w(6);
		chk({bank, fac, fb}, 13'h0014, "bank one active");
		@(posedge clk);
		mode <= 1'b1;
		w(6);
		chk({bank, fac, fb}, 13'h145C, "bank two active");
		wreg(4'h0, 16'h0003);
		@(posedge clk);
		mode <= 1'b0;
		w(6);
		chk(bank, 1'b1, "single bank ignores pin");
		$display("test bank done");
	endtask : t_bank

	task automatic t_mix();
		wreg(4'h2, 16'h000F);
		wreg(4'h3, 16'h0019);
		w(2);
		chk({mix, crs, fine}, 9'h1F3, "mixer and trim");
		$display("test mixer done");
	endtask : t_mix

	initial
	begin
		{nrst, wr, rd, en, mode, addr, wd} = '0;
		mode = 1'b1;
		{err_total, tests_run, tk, fs, bsn, cyc} = '0;
		busy_seen = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		w(2);
		t_reset();
		t_pump();
		t_filter();
		t_xo();
		t_band();
		t_frac();
		t_div();
		t_bank();
		t_mix();
		tally_and_finish();
	end
endmodule : test_pllc_top
`default_nettype wire
